// ===== design/i2csd_pkg.sv
// Package: register map, state codes and engine states of the block
package i2csd_pkg;
    localparam int          AW          = 12;
    localparam int          DW          = 32;
    // Register indices, byte address is four times the index
    localparam logic [7:0]  IDX_DATA    = 8'hbc;
    localparam logic [7:0]  IDX_CODE    = 8'hbd;
    localparam logic [7:0]  IDX_CTRL    = 8'hc0;
    localparam logic [7:0]  IDX_IST     = 8'hc1;
    localparam logic [7:0]  IDX_IMSK    = 8'hc2;
    localparam logic [7:0]  IDX_OWN     = 8'hc3;
    // Field positions
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_ACK    = 1;
    localparam int          IST_SI      = 0;
    localparam int          IST_ERR     = 1;
    // Reset values
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [1:0]  IMSK_RST    = 2'h0;
    localparam logic [6:0]  OWN_RST     = 7'h00;
    localparam logic [7:0]  DATA_RST    = 8'h00;
    // Bus state codes
    localparam logic [7:0]  ST_IDLE     = 8'hf8;
    localparam logic [7:0]  ST_BERR     = 8'h00;
    localparam logic [7:0]  ST_SLA_W    = 8'h60;
    localparam logic [7:0]  ST_RX_ACK   = 8'h80;
    localparam logic [7:0]  ST_RX_NACK  = 8'h88;
    localparam logic [7:0]  ST_STOP     = 8'ha0;
    localparam logic [7:0]  ST_SLA_R    = 8'ha8;
    localparam logic [7:0]  ST_TX_ACK   = 8'hb8;
    localparam logic [7:0]  ST_TX_NACK  = 8'hc0;
    // One bit per code value (code / 8) that the register may hold
    localparam logic [31:0] LEGAL_MASK  = 32'h83f33fff;
    localparam int          NUM_CODES   = 23;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [6:0] {
        E_IDLE = 7'b0000001,
        E_ADDR = 7'b0000010,
        E_AACK = 7'b0000100,
        E_RXD  = 7'b0001000,
        E_RACK = 7'b0010000,
        E_TXD  = 7'b0100000,
        E_TACK = 7'b1000000
    } i2csd_state_t;

    // Whole-word address match for a register index
    function automatic logic hit(logic [AW-1:0] a, logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction

    // Code is one of the supported state codes
    function automatic logic legal_code(logic [7:0] c);
        return LEGAL_MASK[c[7:3]] && (c[2:0] == 3'h0);
    endfunction
endpackage

// ===== design/i2csd_top.sv
// Two-wire data byte and state code registers with slave engine
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module i2csd_top (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [i2csd_pkg::AW-1:0]  awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [i2csd_pkg::DW-1:0]  wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [i2csd_pkg::AW-1:0]  araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [i2csd_pkg::DW-1:0]       rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic                      scl_i,
    output logic                           scl_o,
    output logic                           scl_oe,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe,
    output logic                           irq
);
    import i2csd_pkg::*;

    // All checks run on the core clock, quiet during reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Synchronisers and edge history
    logic [2:0] scl_reg;
    logic [2:0] sda_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
        end else begin
            scl_reg <= {scl_reg[1:0], scl_i};
            sda_reg <= {sda_reg[1:0], sda_i};
        end
    end

    logic scl_s;
    logic sda_s;
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    // Line conditions from the settled samples only
    assign scl_s   = scl_reg[1];
    assign sda_s   = sda_reg[1];
    assign start_c = scl_s && scl_reg[2] && sda_reg[2] && !sda_s;
    assign stop_c  = scl_s && scl_reg[2] && !sda_reg[2] && sda_s;
    assign rise_c  = scl_s && !scl_reg[2];
    assign fall_c  = !scl_s && scl_reg[2];

    // Bus slave state
    logic        awready_reg, awready_next;
    logic        arready_reg, arready_next;
    logic        bvalid_reg,  bvalid_next;
    logic        rvalid_reg,  rvalid_next;
    logic [1:0]  bresp_reg,   bresp_next;
    logic [1:0]  rresp_reg,   rresp_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic        wr_go;
    logic        wr_ok;

    // Engine and register state
    i2csd_state_t st_reg, st_next;
    logic [3:0]  cnt_reg,   cnt_next;
    logic [7:0]  sh_reg,    sh_next;
    logic        rw_reg,    rw_next;
    logic        si_reg,    si_next;
    logic        err_reg,   err_next;
    logic [7:0]  code_reg,  code_next;
    logic [7:0]  pend_reg,  pend_next;
    logic        post_reg,  post_next;
    logic [7:0]  data_reg,  data_next;
    logic        sdaoe_reg, sdaoe_next;
    logic        scloe_reg, scloe_next;
    logic [1:0]  ctrl_reg,  ctrl_next;
    logic [1:0]  msk_reg,   msk_next;
    logic [6:0]  own_reg,   own_next;
    logic        irq_reg,   irq_next;

    assign wr_go = awready_reg;
    assign wr_ok = hit(awaddr, IDX_DATA) || hit(awaddr, IDX_CODE)
                || hit(awaddr, IDX_CTRL) || hit(awaddr, IDX_IST)
                || hit(awaddr, IDX_IMSK) || hit(awaddr, IDX_OWN);

    // Bus handshakes, write answer and read mux
    always_comb begin
        awready_next = awvalid && wvalid && !awready_reg && !bvalid_reg;
        arready_next = arvalid && !arready_reg && !rvalid_reg;
        bvalid_next  = bvalid_reg && !bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !rready;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0;
            if (hit(araddr, IDX_DATA)) begin
                rdata_next[7:0] = data_reg;
            end else if (hit(araddr, IDX_CODE)) begin
                rdata_next[7:0] = {code_reg[7:3], 3'h0};
            end else if (hit(araddr, IDX_CTRL)) begin
                rdata_next[1:0] = ctrl_reg;
            end else if (hit(araddr, IDX_IST)) begin
                rdata_next[1:0] = {err_reg, si_reg};
            end else if (hit(araddr, IDX_IMSK)) begin
                rdata_next[1:0] = msk_reg;
            end else if (hit(araddr, IDX_OWN)) begin
                rdata_next[6:0] = own_reg;
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            rvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0;
        end else begin
            awready_reg <= awready_next;
            arready_reg <= arready_next;
            bvalid_reg  <= bvalid_next;
            rvalid_reg  <= rvalid_next;
            bresp_reg   <= bresp_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Bus state engine, software writes and interrupt
    always_comb begin
        logic       post;
        logic [7:0] pc;
        logic       wb;
        post       = 1'b0;
        pc         = ST_BERR;
        wb         = wr_go && wstrb[0];
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        rw_next    = rw_reg;
        err_next   = err_reg;
        data_next  = data_reg;
        sdaoe_next = sdaoe_reg;
        ctrl_next  = ctrl_reg;
        msk_next   = msk_reg;
        own_next   = own_reg;
        if (!ctrl_reg[CTRL_EN]) begin
            st_next    = E_IDLE;
            sdaoe_next = 1'b0;
        end else if (si_reg) begin
            // Stalled; on release the first sent bit goes out
            if (wb && hit(awaddr, IDX_IST) && wdata[IST_SI]
                && st_reg == E_TXD) begin
                sh_next    = data_reg;
                sdaoe_next = !data_reg[7];
            end
        end else if (start_c && st_reg != E_IDLE) begin
            sdaoe_next = 1'b0;
            cnt_next   = 4'h0;
            post       = 1'b1;
            // One rise seen: the condition sits at a byte boundary
            if (cnt_reg == 4'h1 && st_reg != E_ADDR) begin
                pc      = ST_STOP;
                st_next = E_ADDR;
            end else begin
                pc       = ST_BERR;
                err_next = 1'b1;
                st_next  = E_IDLE;
                post     = (st_reg != E_ADDR) || (cnt_reg != 4'h1);
            end
        end else if (stop_c && st_reg != E_IDLE) begin
            sdaoe_next = 1'b0;
            st_next    = E_IDLE;
            if (cnt_reg != 4'h1) begin
                pc       = ST_BERR;
                err_next = 1'b1;
                post     = 1'b1;
            end else if (st_reg != E_ADDR) begin
                pc   = ST_STOP;
                post = 1'b1;
            end
        end else begin
            case (st_reg)
                E_IDLE: begin
                    if (start_c) begin
                        st_next  = E_ADDR;
                        cnt_next = 4'h0;
                    end
                end
                E_ADDR, E_RXD: begin
                    if (rise_c) begin
                        sh_next  = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall_c && cnt_reg == BITS_BYTE) begin
                        cnt_next = 4'h0;
                        if (st_reg == E_RXD) begin
                            data_next  = sh_reg;
                            sdaoe_next = ctrl_reg[CTRL_ACK];
                            st_next    = E_RACK;
                        end else if (sh_reg[7:1] == own_reg) begin
                            sdaoe_next = 1'b1;
                            rw_next    = sh_reg[0];
                            st_next    = E_AACK;
                        end else begin
                            st_next = E_IDLE;
                        end
                    end
                end
                E_AACK, E_RACK: begin
                    if (fall_c) begin
                        sdaoe_next = 1'b0;
                        post       = 1'b1;
                        if (st_reg == E_RACK) begin
                            pc      = ctrl_reg[CTRL_ACK] ? ST_RX_ACK
                                                         : ST_RX_NACK;
                            st_next = E_RXD;
                        end else begin
                            pc      = rw_reg ? ST_SLA_R : ST_SLA_W;
                            st_next = rw_reg ? E_TXD : E_RXD;
                        end
                    end
                end
                E_TXD: begin
                    if (rise_c) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall_c && cnt_reg == BITS_BYTE) begin
                        sdaoe_next = 1'b0;
                        cnt_next   = 4'h0;
                        st_next    = E_TACK;
                    end else if (fall_c) begin
                        sh_next    = {sh_reg[6:0], 1'b0};
                        sdaoe_next = !sh_reg[6];
                    end
                end
                default: begin
                    if (rise_c) begin
                        sh_next[0] = !sda_s;
                    end else if (fall_c) begin
                        post    = 1'b1;
                        pc      = sh_reg[0] ? ST_TX_ACK : ST_TX_NACK;
                        st_next = sh_reg[0] ? E_TXD : E_IDLE;
                    end
                end
            endcase
        end
        // Software writes; data byte taken only while stalled or idle
        if (wb && hit(awaddr, IDX_DATA) && (si_reg || st_reg == E_IDLE))
            data_next = wdata[7:0];
        if (wb && hit(awaddr, IDX_CTRL))
            ctrl_next = wdata[1:0];
        if (wb && hit(awaddr, IDX_IMSK))
            msk_next = wdata[1:0];
        if (wb && hit(awaddr, IDX_OWN))
            own_next = wdata[7:1];
        // Flags: a new event wins over a clearing write
        si_next = si_reg;
        if (wb && hit(awaddr, IDX_IST) && wdata[IST_ERR])
            err_next = 1'b0;
        if (wb && hit(awaddr, IDX_IST) && wdata[IST_SI])
            si_next = 1'b0;
        if (post)
            si_next = 1'b1;
        if (post && pc == ST_BERR)
            err_next = 1'b1;
        post_next = post;
        pend_next = post ? pc : pend_reg;
        // Code lands one cycle after the flag; idle code after release once the engine is idle
        code_next = code_reg;
        if (post_reg)
            code_next = pend_reg;
        else if (!si_reg && code_reg != ST_IDLE && st_reg == E_IDLE)
            code_next = ST_IDLE;
        // Clock held low while stalled with the line low and the next engine state not idle
        scloe_next = si_next && st_next != E_IDLE
                     && (scloe_reg || !scl_s);
        irq_next   = |({err_next, si_next} & msk_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg    <= E_IDLE;
            cnt_reg   <= 4'h0;
            sh_reg    <= 8'h00;
            rw_reg    <= 1'b0;
            si_reg    <= 1'b0;
            err_reg   <= 1'b0;
            code_reg  <= ST_IDLE;
            pend_reg  <= ST_IDLE;
            post_reg  <= 1'b0;
            data_reg  <= DATA_RST;
            sdaoe_reg <= 1'b0;
            scloe_reg <= 1'b0;
            ctrl_reg  <= CTRL_RST;
            msk_reg   <= IMSK_RST;
            own_reg   <= OWN_RST;
            irq_reg   <= 1'b0;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            rw_reg    <= rw_next;
            si_reg    <= si_next;
            err_reg   <= err_next;
            code_reg  <= code_next;
            pend_reg  <= pend_next;
            post_reg  <= post_next;
            data_reg  <= data_next;
            sdaoe_reg <= sdaoe_next;
            scloe_reg <= scloe_next;
            ctrl_reg  <= ctrl_next;
            msk_reg   <= msk_next;
            own_reg   <= own_next;
            irq_reg   <= irq_next;
        end
    end

    // Outputs, all from flip-flops or constants
    assign awready = awready_reg;
    assign wready  = awready_reg;
    assign bresp   = bresp_reg;
    assign bvalid  = bvalid_reg;
    assign arready = arready_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;
    assign rvalid  = rvalid_reg;
    assign scl_o   = 1'b0;
    assign sda_o   = 1'b0;
    assign scl_oe  = scloe_reg;
    assign sda_oe  = sdaoe_reg;
    assign irq     = irq_reg;

    // Checks on the block's own behaviour
    code_low_zero_a: assert property (
        arready_reg && hit(araddr, IDX_CODE) |=> rdata[2:0] == 3'h0)
        else $error("code low bits not zero");
    code_field_a: assert property (
        arready_reg && hit(araddr, IDX_CODE)
        |=> rdata[7:3] == $past(code_reg[7:3]))
        else $error("code field mismatch");
    code_legal_a: assert property (
        legal_code(code_reg) && legal_code(pend_reg))
        else $error("unsupported code value");
    idle_no_req_a: assert property (
        code_reg == ST_IDLE && si_reg |-> post_reg)
        else $error("flag set with idle code");
    post_sets_si_a: assert property (
        post_next |=> si_reg && pend_reg != ST_IDLE)
        else $error("event did not set flag");
    code_follows_a: assert property (
        $rose(post_reg) |=> code_reg == $past(pend_reg))
        else $error("code not one cycle after flag");
    data_rx_a: assert property (
        st_reg == E_RXD && st_next == E_RACK && !si_reg
        |=> data_reg == $past(sh_reg))
        else $error("received byte not stored");
    code_hold_a: assert property (
        si_reg && !post_reg |=> $stable(code_reg))
        else $error("code changed while flag set");
    berr_code_a: assert property (
        post_reg && pend_reg == ST_BERR |-> err_reg ##1 code_reg == ST_BERR)
        else $error("bus error not reported");
    stall_hold_a: assert property (
        si_reg && !post_reg && ctrl_reg[CTRL_EN] |-> $stable(st_reg))
        else $error("engine moved while stalled");
endmodule

// ===== sim/i2csd_master.sv
// Two-wire bus master model driving the far side of the link
`timescale 1ns/100ps
module i2csd_master (
    input  wire logic aclk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_pull,
    output logic      sda_pull
);
    int stalls;

    // Lines released, clock stands still between frames
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        stalls = 0;
    end

    // Half of the 800 ns link period
    task automatic half();
        repeat (4) @(posedge aclk);
    endtask

    // Release clock, wait out a stretch by the slave
    task automatic clk_hi();
        int n;
        n = 0;
        scl_pull <= 1'b0;
        @(posedge aclk);
        while (scl_in !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        if (n == 2000) stalls++;
        half();
    endtask

    // One bit, data set while clock low, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        half();
        clk_hi();
        r = sda_in;
        scl_pull <= 1'b1;
        half();
    endtask

    // Data falls while clock high
    task automatic start();
        sda_pull <= 1'b1;
        half();
        scl_pull <= 1'b1;
        half();
    endtask

    // Data rises while clock high
    task automatic stop();
        sda_pull <= 1'b1;
        half();
        clk_hi();
        sda_pull <= 1'b0;
        half();
    endtask

    // Byte out MSB first, then the slave's answer bit
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Byte in MSB first, then our own answer bit
    task automatic byte_in(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask
endmodule

// ===== sim/tb_top.sv
// Bench: register bus driver, link master and state model checks
`timescale 1ns/100ps
module tb_top;
    import i2csd_pkg::*;
    logic          aclk, aresetn, awvalid, awready, wvalid, wready;
    logic          bvalid, bready, arvalid, arready, rvalid, rready;
    logic          scl_o, scl_oe, sda_o, sda_oe, irq, scl_pull, sda_pull;
    logic [AW-1:0] awaddr, araddr;
    logic [DW-1:0] wdata, rdata, rd, sts;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, rsp, m_mask;
    logic [6:0]    own;
    logic [7:0]    tx, rx;
    logic          ack;
    wire           scl_line, sda_line;
    int            error_cnt, n_tests;
    int            exp_q[$];

    // Open-drain lines with pull-ups
    assign scl_line = ~((scl_oe & ~scl_o) | scl_pull);
    assign sda_line = ~((sda_oe & ~sda_o) | sda_pull);

    i2csd_top u_i2csd_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .scl_i(scl_line), .scl_o, .scl_oe, .sda_i(sda_line), .sda_o,
        .sda_oe, .irq);

    i2csd_master u_i2csd_master (.aclk, .scl_in(scl_line),
        .sda_in(sda_line), .scl_pull, .sda_pull);

    // 10 MHz core clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [AW-1:0] adr(logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp=%h got=%h", name, exp, got);
        end
    endtask

    task automatic hang();
        check("wait_done", 32'h0, 32'h1);
        conclude();
    endtask

    // Write: address and data offered together, released when taken
    task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= adr(idx);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        @(posedge aclk);
        if (n == 50) hang();
    endtask

    // Read: result left in rd and rsp
    task automatic axi_rd(input logic [AW-1:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (n == 50) hang();
    endtask

    // Wait for the flag, then compare code, irq and clock stretch
    task automatic take_state(input logic [7:0] code);
        int   n;
        logic hold;
        n = 0;
        // Clock is held only while a transfer is still open
        hold = !(code inside {ST_STOP, ST_BERR, ST_TX_NACK});
        exp_q.push_back(code);
        sts = '0;
        while (sts[IST_SI] !== 1'b1 && n < 100) begin
            axi_rd(adr(IDX_IST));
            sts = rd;
            n++;
        end
        if (n == 100) hang();
        axi_rd(adr(IDX_CODE));
        check("state_code", rd, 32'(exp_q.pop_front()));
        check("code_low", {29'h0, rd[2:0]}, 32'h0);
        check("irq_on", {31'h0, irq}, {31'h0, m_mask[IST_SI]});
        check("stretch", {31'h0, scl_oe}, {31'h0, hold});
    endtask

    // Clear status bits, then the code must fall back to idle
    task automatic clr_idle(input logic [1:0] bits);
        axi_wr(IDX_IST, {30'h0, bits});
        axi_rd(adr(IDX_CODE));
        check("code_idle", rd, {24'h0, ST_IDLE});
        check("irq_idle", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        error_cnt = 0;
        n_tests = 0;
        void'($urandom(32'hb83ab96b));
        own = 7'($urandom_range(119, 8));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and an unmapped place
        axi_rd(adr(IDX_CODE));
        check("code_rst", rd, {24'h0, ST_IDLE});
        check("irq_rst", {31'h0, irq}, 32'h0);
        axi_rd(adr(IDX_DATA));
        check("data_rst", rd, {24'h0, DATA_RST});
        axi_rd(12'hffc);
        check("unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        axi_wr(IDX_OWN, {24'h0, own, 1'b0});
        axi_wr(IDX_CTRL, 32'h3);
        axi_wr(IDX_IMSK, 32'h3);
        m_mask = 2'h3;
        // Other address: no answer, no state
        u_i2csd_master.start();
        u_i2csd_master.byte_out({own ^ 7'h01, 1'b0}, ack);
        u_i2csd_master.stop();
        axi_rd(adr(IDX_IST));
        check("foreign", {rd[1:0], 7'h0, ack}, 32'h0);
        // Write transfer: address, one byte, stop
        tx = 8'($urandom);
        u_i2csd_master.start();
        u_i2csd_master.byte_out({own, 1'b0}, ack);
        take_state(ST_SLA_W);
        axi_wr(IDX_IST, 32'h1);
        check("released", {31'h0, scl_oe}, 32'h0);
        u_i2csd_master.byte_out(tx, ack);
        take_state(ST_RX_ACK);
        axi_rd(adr(IDX_DATA));
        check("rx_byte", {ack, rd[30:0]}, {1'b1, 23'h0, tx});
        axi_wr(IDX_IST, 32'h1);
        u_i2csd_master.stop();
        take_state(ST_STOP);
        clr_idle(2'h1);
        // Read transfer: two bytes, master answers ack then nack
        u_i2csd_master.start();
        u_i2csd_master.byte_out({own, 1'b1}, ack);
        take_state(ST_SLA_R);
        for (int i = 0; i < 2; i++) begin
            tx = 8'($urandom);
            axi_wr(IDX_DATA, {24'h0, tx});
            axi_wr(IDX_IST, 32'h1);
            u_i2csd_master.byte_in(1'(i), rx);
            check("tx_byte", {24'h0, rx}, {24'h0, tx});
            take_state(i == 0 ? ST_TX_ACK : ST_TX_NACK);
        end
        axi_wr(IDX_IST, 32'h1);
        u_i2csd_master.stop();
        // Stop inside a data byte, interrupt masked first
        axi_wr(IDX_IMSK, 32'h0);
        m_mask = 2'h0;
        u_i2csd_master.start();
        u_i2csd_master.byte_out({own, 1'b0}, ack);
        take_state(ST_SLA_W);
        axi_wr(IDX_IST, 32'h1);
        for (int i = 0; i < 3; i++) u_i2csd_master.bit_io(1'(i != 1), ack);
        u_i2csd_master.stop();
        take_state(ST_BERR);
        check("err_bit", {31'h0, sts[IST_ERR]}, 32'h1);
        axi_wr(IDX_IMSK, 32'h3);
        check("irq_unmask", {31'h0, irq}, 32'h1);
        clr_idle(2'h3);
        check("stalls", 32'(u_i2csd_master.stalls), 32'h0);
        conclude();
    end
endmodule
